/* File: hdl/epwc_defines.vh */
// Constants for the expander interrupt, write-block, strap and PWM block
`ifndef EPWC_DEFINES_VH
`define EPWC_DEFINES_VH
`define EPWC_NPIN       8
`define EPWC_NCH        4
// APB byte addresses; EPWC_I_ENABLE is the enable register's word index
`define EPWC_A_OUT      8'h00
`define EPWC_A_PWMSEL   8'h04
`define EPWC_A_MASK     8'h08
`define EPWC_A_ISTAT    8'h0C
`define EPWC_A_INPUT    8'h10
`define EPWC_A_DIR      8'h14
`define EPWC_A_STRAP    8'h18
`define EPWC_I_ENABLE   8'h2D
`define EPWC_A_ENABLE   8'hB4
`define EPWC_A_PWM0     8'h40
// PWM channel stride and field offsets
`define EPWC_PWM_STRIDE 8'h10
`define EPWC_PWM_CFG    4'h0
`define EPWC_PWM_PER    4'h4
`define EPWC_PWM_WID    4'h8
// Enable register bits
`define EPWC_EN_INT     0
`define EPWC_EN_WP      1
`define EPWC_EN_EE      2
`define EPWC_EN_RO      3
// Reset values
`define EPWC_RST_OUT    8'hFF
`define EPWC_RST_MASK   8'hFF
`define EPWC_RST_DIR    8'hFF
`define EPWC_RST_SEL    8'h00
`define EPWC_RST_EN     8'h04
`define EPWC_RST_PER    8'hFF
`define EPWC_RST_WID    8'h00
// Clock source codes
`define EPWC_SRC_32K    3'h0
`define EPWC_SRC_24M    3'h1
`define EPWC_SRC_1M5    3'h2
`define EPWC_SRC_94K    3'h3
`define EPWC_SRC_SLOW   3'h4
`define EPWC_SRC_PREV   3'h5
`endif

/* File: hdl/epwc_top.v */
// Interrupt, EEPROM write-block, external reset, strap and PWM logic
`include "epwc_defines.vh"
`default_nettype none
module epwc_top (
  input  wire        clk_in,                  // 125 MHz core clock
  input  wire        reset_n_in,              // Synchronous, active low
  input  wire        external_reset_pin_in,   // Active high, asynchronous
  input  wire        psel_in,                 // APB select
  input  wire        penable_in,              // APB access phase
  input  wire        pwrite_in,               // APB direction
  input  wire [7:0]  paddr_in,                // APB byte address
  input  wire [31:0] pwdata_in,               // APB write data
  output reg  [31:0] prdata_out,              // APB read data
  output wire        pready_out,              // APB ready
  output wire        pslverr_out,             // APB error
  input  wire [4:0]  clk_src_tick_in,         // Source ticks, same domain
  input  wire [7:0]  general_port_in,         // Pin levels
  output reg  [7:0]  general_port_out,        // Pin drive values
  output reg  [7:0]  general_port_oe_out,     // Pin drive enables
  output reg         int_out,                 // Interrupt, active high
  output wire        int_oe_out,              // Interrupt drive enable
  input  wire        eeprom_write_block_pin_in, // Write-block pin
  input  wire        eeprom_cmd_req_in,       // EEPROM command start pulse
  output reg         eeprom_cmd_grant_out,    // Command allowed, pulse
  output reg         eeprom_cmd_deny_out,     // Command rejected, pulse
  input  wire        addr_strap_first_in,     // First strap level
  input  wire [5:0]  addr_strap_chain_in,     // Chain strap levels
  input  wire [6:0]  addr_strap_strong_in,    // Strap is strongly pulled
  output reg  [6:0]  slave_addr_bits_out,     // Captured address bits
  output reg  [6:0]  addr_pin_used_out        // Pin serves as address
);

  // Synchronisers: stage one is read only by stage two
  // Stage three of the pins is an edge detector, not a sync stage
  reg [7:0]  pin_s1_ff, pin_s2_ff, pin_s3_ff;
  reg [1:0]  external_reset_pin_s_ff;
  reg [1:0]  wp_s_ff;
  reg [13:0] strap_s1_ff, strap_s2_ff;

  // Register file
  // All storage below resets on the combined core reset
  reg [7:0]  out_ff;        // Output port bits
  reg [7:0]  sel_ff;        // PWM select bits
  reg [7:0]  mask_ff;       // Interrupt mask, 1 masks
  reg [7:0]  dir_ff;        // Direction, 1 is input
  reg [7:0]  en_ff;         // Enable register
  reg [7:0]  istat_ff;      // Change status
  reg [7:0]  ipend_ff;      // Status bits eligible for the line
  reg        strap_done_ff; // Straps captured once after reset
  reg [2:0]  src_ff [0:`EPWC_NCH-1];
  reg [7:0]  per_ff [0:`EPWC_NCH-1];
  reg [7:0]  wid_ff [0:`EPWC_NCH-1];
  reg [7:0]  cnt_ff [0:`EPWC_NCH-1];
  reg [`EPWC_NCH-1:0] pwm_ff;      // Channel outputs
  reg [`EPWC_NCH-1:0] pwm_prev_ff; // For toggle and chain edges

  wire       rst_int;      // Combined core reset
  wire       wr_acc;       // APB write access
  wire       rd_acc;       // APB read access
  wire       hit_pwm;      // Address in PWM window
  wire [1:0] pwm_ch;       // Channel addressed
  wire [3:0] pwm_fld;      // Field within channel
  reg        mapped;       // Address decodes
  reg [7:0]  rd_mux;       // Read data before flop
  reg [7:0]  nxt_istat;
  reg [7:0]  nxt_ipend;
  wire [7:0] pin_change;   // Synced pin edges
  wire [`EPWC_NCH-1:0] step; // Counter advance per channel
  wire [7:0] pin_pwm;      // Channel output per pin
  wire [7:0] pwm_tog;      // PWM toggle per pin
  wire [7:0] pwm_slow;     // Toggle from slowest source
  wire       wp_active;    // Write-block function in force

  // External reset acts as a full reset, same as power-on
  // The pin is seen two edges late through its synchroniser, so
  // a glitch shorter than a cycle may pass unnoticed
  assign rst_int = ~reset_n_in | external_reset_pin_s_ff[1];

  // APB: zero wait states, error on unmapped address
  // Writes take effect at the access edge; reads have no side
  // effect except on the status register
  assign pready_out  = 1'b1;
  assign wr_acc      = psel_in & penable_in & pwrite_in;
  assign rd_acc      = psel_in & penable_in & ~pwrite_in;
  assign hit_pwm     = (paddr_in[7:6] == 2'b01) & (paddr_in[1:0] == 2'b00);
  assign pwm_ch      = paddr_in[5:4];
  assign pwm_fld     = paddr_in[3:0];
  assign pslverr_out = psel_in & penable_in & ~mapped;
  assign int_oe_out  = 1'b1; // Never open drain

  // Synchronisers and the pin edge stage run free, with no reset
  // A reset to zero would make a pin that is high at release look
  // like a fresh change, and would hand the strap capture zeros
  // instead of the strapped levels on the first edge after reset.
  // Board reset is held for several cycles, which flushes them.
  always @(posedge clk_in) begin
    pin_s1_ff   <= general_port_in;      // Read by stage two only
    pin_s2_ff   <= pin_s1_ff;            // Settled pin levels
    pin_s3_ff   <= pin_s2_ff;            // One cycle older, for edges
    external_reset_pin_s_ff   <= {external_reset_pin_s_ff[0], external_reset_pin_in};
    wp_s_ff     <= {wp_s_ff[0], eeprom_write_block_pin_in};
    strap_s1_ff <= {addr_strap_strong_in, addr_strap_chain_in,
                    addr_strap_first_in};
    strap_s2_ff <= strap_s1_ff;
  end

  // Address decode and read data selection
  // Channel fields sit in a window of 16-byte strides; the
  // unused fourth field of each channel reports an error
  always @* begin
    mapped = 1'b1;
    rd_mux = 8'h00;
    if (hit_pwm) begin
      case (pwm_fld)
        `EPWC_PWM_CFG: rd_mux = {5'h00, src_ff[pwm_ch]};
        `EPWC_PWM_PER: rd_mux = per_ff[pwm_ch];
        `EPWC_PWM_WID: rd_mux = wid_ff[pwm_ch];
        default:       mapped = 1'b0;
      endcase
    end else begin
      case (paddr_in)
        `EPWC_A_OUT:    rd_mux = out_ff;
        `EPWC_A_PWMSEL: rd_mux = sel_ff;
        `EPWC_A_MASK:   rd_mux = mask_ff;
        `EPWC_A_ISTAT:  rd_mux = istat_ff;
        `EPWC_A_INPUT:  rd_mux = pin_s2_ff;
        `EPWC_A_DIR:    rd_mux = dir_ff;
        `EPWC_A_STRAP:  rd_mux = {1'b0, slave_addr_bits_out};
        `EPWC_A_ENABLE: rd_mux = en_ff;
        default:        mapped = 1'b0;
      endcase
    end
  end

  // Read data captured in the setup cycle, stable in access
  // Capturing early keeps the status read and its clear apart:
  // the bits shown are those held before the setup edge
  always @(posedge clk_in) begin
    if (rst_int) begin
      prdata_out <= 32'h00000000;
    end else if (psel_in & ~penable_in) begin
      prdata_out <= {24'h000000, rd_mux};
    end
  end

  // Control registers written by software
  // Read-only and unmapped addresses leave every register as is
  always @(posedge clk_in) begin
    if (rst_int) begin
      out_ff  <= `EPWC_RST_OUT;
      sel_ff  <= `EPWC_RST_SEL;
      mask_ff <= `EPWC_RST_MASK;
      dir_ff  <= `EPWC_RST_DIR;
      en_ff   <= `EPWC_RST_EN;
    end else if (wr_acc) begin
      case (paddr_in)
        `EPWC_A_OUT:    out_ff  <= pwdata_in[7:0];
        `EPWC_A_PWMSEL: sel_ff  <= pwdata_in[7:0];
        `EPWC_A_MASK:   mask_ff <= pwdata_in[7:0];
        `EPWC_A_DIR:    dir_ff  <= pwdata_in[7:0];
        `EPWC_A_ENABLE: en_ff   <= pwdata_in[7:0];
        default:        out_ff  <= out_ff;
      endcase
    end
  end

  // Pin i uses channel i modulo the channel count
  // A toggle counts only on a pin routed to its channel, so a
  // free-running channel on a plain pin never sets status
  genvar gi;
  generate
    for (gi = 0; gi < `EPWC_NPIN; gi = gi + 1) begin : g_pin
      assign pin_pwm[gi]  = pwm_ff[gi % `EPWC_NCH];
      assign pwm_tog[gi]  = sel_ff[gi] &
                            (pwm_ff[gi % `EPWC_NCH] ^
                             pwm_prev_ff[gi % `EPWC_NCH]);
      assign pwm_slow[gi] = pwm_tog[gi] &
                            (src_ff[gi % `EPWC_NCH] == `EPWC_SRC_SLOW);
    end
  endgenerate

  // Pin drive: PWM only when both output and select bits set
  // Registered so the pin never shows decode glitches; the price
  // is one cycle of delay after each write or channel step
  always @(posedge clk_in) begin
    if (rst_int) begin
      general_port_out    <= 8'h00;
      general_port_oe_out <= 8'h00; // High-Z while reset held
    end else begin
      general_port_out    <= out_ff & (~sel_ff | pin_pwm);
      general_port_oe_out <= ~dir_ff;
    end
  end

  // Edges of input pins; driven pins change too, by design
  // Comparing the last two synced stages gives a one-cycle pulse
  // per level change, whichever way the pin moved
  assign pin_change = pin_s2_ff ^ pin_s3_ff;

  // Status: set wins over clear-on-read
  // An event in the cycle of the read survives; one that sets a bit at the
  // setup edge misses the captured read data and is cleared at the access edge
  always @* begin
    nxt_istat = istat_ff;
    nxt_ipend = ipend_ff;
    if (rd_acc && paddr_in == `EPWC_A_ISTAT) begin
      nxt_istat = 8'h00; // Whole register clears on read
      nxt_ipend = 8'h00; // Releases the line
    end
    nxt_istat = nxt_istat | pin_change | pwm_tog;
    // Pin changes and, of the PWM toggles, only slowest-source ones may pull the line
    nxt_ipend = nxt_ipend | pin_change | pwm_slow;
  end

  // Status and interrupt line
  // The line follows the next pending value so it rises in the
  // same cycle as the status bit; mask and enable act at once
  always @(posedge clk_in) begin
    if (rst_int) begin
      istat_ff <= 8'h00;
      ipend_ff <= 8'h00;
      int_out  <= 1'b0;
    end else begin
      istat_ff <= nxt_istat;
      ipend_ff <= nxt_ipend;
      // Mask bit zero enables the pin's event
      int_out  <= en_ff[`EPWC_EN_INT] & (|(nxt_ipend & ~mask_ff));
    end
  end

  // Write-block active only with EEPROM on and writable
  // Read-only or disabled memory cannot be written anyway, so
  // the pin has nothing to guard there
  assign wp_active = en_ff[`EPWC_EN_WP] & en_ff[`EPWC_EN_EE] &
                     ~en_ff[`EPWC_EN_RO];

  // Decide each EEPROM command from the pin seen at its start
  // Exactly one of grant and deny answers each request, one
  // cycle later; the pin level that counts is the synced one
  // standing at the request edge, not an earlier one
  always @(posedge clk_in) begin
    if (rst_int) begin
      eeprom_cmd_grant_out <= 1'b0;
      eeprom_cmd_deny_out  <= 1'b0;
    end else begin
      // Any command kind, sampled at request time
      eeprom_cmd_grant_out <= eeprom_cmd_req_in &
                              ~(wp_active & wp_s_ff[1]);
      eeprom_cmd_deny_out  <= eeprom_cmd_req_in & wp_active & wp_s_ff[1];
    end
  end

  // Strap capture once the synchronisers have settled after reset
  // Pin k joins the address only if every earlier pin is weak;
  // the first strong pin is the last address pin
  integer k;
  reg       chain_on;
  reg [6:0] nxt_used;
  always @* begin
    chain_on = 1'b1;
    nxt_used = 7'h00;
    for (k = 0; k < 7; k = k + 1) begin
      nxt_used[k] = chain_on;
      // Strong pull ends the chain; later pins stay GPIO
      if (strap_s2_ff[7 + k]) begin
        chain_on = 1'b0;
      end
    end
  end

  // Straps are read once per reset; later pin motion is ignored,
  // so pins released to general use may change freely
  always @(posedge clk_in) begin
    if (rst_int) begin
      strap_done_ff       <= 1'b0;
      slave_addr_bits_out <= 7'h00;
      addr_pin_used_out   <= 7'h00;
    end else if (!strap_done_ff) begin
      // Straps have been synced through reset, so they are valid here
      strap_done_ff       <= 1'b1;
      // First strap is always an address bit
      slave_addr_bits_out <= strap_s2_ff[6:0] & nxt_used;
      addr_pin_used_out   <= nxt_used;
    end
  end

  // PWM channels: source pick, chain edge, counter and output
  // Channel n may count the rising edges of channel n-1, so a
  // chain of channels divides a source down further.
  // Software must keep period 1..FFh and width below period.
  genvar gc;
  generate
    for (gc = 0; gc < `EPWC_NCH; gc = gc + 1) begin : g_ch
      localparam integer PRV = (gc + `EPWC_NCH - 1) % `EPWC_NCH;
      reg src_tick;
      // Source selection; previous channel via edge detect
      always @* begin
        case (src_ff[gc])
          `EPWC_SRC_32K:  src_tick = clk_src_tick_in[0];
          `EPWC_SRC_24M:  src_tick = clk_src_tick_in[1];
          `EPWC_SRC_1M5:  src_tick = clk_src_tick_in[2];
          `EPWC_SRC_94K:  src_tick = clk_src_tick_in[3];
          `EPWC_SRC_SLOW: src_tick = clk_src_tick_in[4];
          `EPWC_SRC_PREV: src_tick = pwm_ff[PRV] & ~pwm_prev_ff[PRV];
          default:        src_tick = 1'b0;
        endcase
      end
      assign step[gc] = src_tick;

      // Channel registers and counter
      // Field writes take effect at the access edge; the counter
      // keeps running and a new period applies from its next step
      always @(posedge clk_in) begin
        if (rst_int) begin
          src_ff[gc]      <= `EPWC_SRC_32K;
          per_ff[gc]      <= `EPWC_RST_PER;
          wid_ff[gc]      <= `EPWC_RST_WID;
          cnt_ff[gc]      <= 8'h00;
          pwm_ff[gc]      <= 1'b0;
          pwm_prev_ff[gc] <= 1'b0;
        end else begin
          pwm_prev_ff[gc] <= pwm_ff[gc];
          if (wr_acc && hit_pwm && pwm_ch == gc) begin
            if (pwm_fld == `EPWC_PWM_CFG) begin
              src_ff[gc] <= pwdata_in[2:0];
            end
            if (pwm_fld == `EPWC_PWM_PER) begin
              per_ff[gc] <= pwdata_in[7:0]; // 1..FFh expected
            end
            if (pwm_fld == `EPWC_PWM_WID) begin
              wid_ff[gc] <= pwdata_in[7:0]; // Below period
            end
          end
          // Period zero freezes the channel rather than misbehave
          // A count above a new, shorter period wraps on its next step
          if (step[gc] && per_ff[gc] != 8'h00) begin
            // Wrap after period counts
            if (cnt_ff[gc] >= per_ff[gc] - 8'h01) begin
              cnt_ff[gc] <= 8'h00;
              pwm_ff[gc] <= (wid_ff[gc] != 8'h00);
            end else begin
              cnt_ff[gc] <= cnt_ff[gc] + 8'h01;
              pwm_ff[gc] <= (cnt_ff[gc] + 8'h01 < wid_ff[gc]);
            end
          end
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

/* File: verif/epwc_ticks.sv */
// Source tick model: a free 64 ns clock plus dividers
`default_nettype none
module epwc_ticks (
  input  wire logic       clk_in,   // Core clock
  output var  logic [4:0] tick_out  // One-cycle ticks per source
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       slow_clk = 1'b0;  // Unrelated to clk_in in phase
  logic [1:0] smp_ff = 2'h0;    // Two stages against metastability
  logic       old_ff = 1'b0;    // Last synced level, for edges
  logic [3:0] div_ff = 4'h0;    // Divider for sources 2 to 4; source 1 ticks every cycle
  always #32 slow_clk = ~slow_clk;
  // Sample the slow clock and count core cycles
  always_ff @(posedge clk_in) begin
    smp_ff <= {smp_ff[0], slow_clk};
    old_ff <= smp_ff[1];
    div_ff <= div_ff + 4'h1;
  end
  // Code 4 is the slowest, one tick in 16 cycles
  assign tick_out = {div_ff == 4'hF, div_ff[1:0] == 2'h3, div_ff[0],
                     1'b1, smp_ff[1] & ~old_ff};
endmodule
`default_nettype wire

/* File: verif/epwc_top_asserts.sv */
// Port assertions for interrupt, write-block, reset and strap logic
`include "epwc_defines.vh"
`default_nettype none
module epwc_top_asserts (
  input wire logic        clk_in,
  input wire logic        reset_n_in,
  input wire logic        external_reset_pin_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [7:0]  paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [7:0]  general_port_in,
  input wire logic [7:0]  general_port_oe_out,
  input wire logic        int_out,
  input wire logic        int_oe_out,
  input wire logic        eeprom_write_block_pin_in,
  input wire logic        eeprom_cmd_req_in,
  input wire logic        eeprom_cmd_grant_out,
  input wire logic        eeprom_cmd_deny_out,
  input wire logic [6:0]  slave_addr_bits_out,
  input wire logic [6:0]  addr_pin_used_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] en_ff;    // Enable register mirror
  logic [7:0] mask_ff;  // Mask register mirror
  logic [7:0] sel_ff;   // PWM select mirror
  logic [7:0] gp_ff;    // Pins one cycle ago
  logic [3:0] wp_ff;    // Write-block pin history
  logic [3:0] xr_ff;    // External reset history
  logic [2:0] q_ff;     // Quiet cycles, saturating
  wire wr = psel_in & penable_in & pwrite_in;
  wire rd = psel_in & penable_in & ~pwrite_in & paddr_in == `EPWC_A_ISTAT;
  wire chg = general_port_in != gp_ff;
  wire calm = xr_ff == 4'h0 & ~external_reset_pin_in;
  wire wp_on = en_ff[1] & en_ff[2] & ~en_ff[3];
  wire req = eeprom_cmd_req_in;
  wire ok = eeprom_cmd_grant_out & ~eeprom_cmd_deny_out;
  // Mirrors clear a little early on the pin; calm covers the gap
  always_ff @(posedge clk_in) begin
    gp_ff <= general_port_in;
    wp_ff <= {wp_ff[2:0], eeprom_write_block_pin_in};
    xr_ff <= {xr_ff[2:0], external_reset_pin_in};
    q_ff <= (chg | ~reset_n_in) ? 3'h0 : q_ff + {2'h0, q_ff != 3'h7};
    if (!reset_n_in || external_reset_pin_in) begin
      en_ff <= `EPWC_RST_EN;
      mask_ff <= `EPWC_RST_MASK;
      sel_ff <= `EPWC_RST_SEL;
    end else if (wr && paddr_in == `EPWC_A_ENABLE) begin
      en_ff <= pwdata_in[7:0];
    end else if (wr && paddr_in == `EPWC_A_MASK) begin
      mask_ff <= pwdata_in[7:0];
    end else if (wr && paddr_in == `EPWC_A_PWMSEL) begin
      sel_ff <= pwdata_in[7:0];
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  a_int_drive: assert property (int_oe_out)
    else $error("interrupt pin not driven");
  a_int_rise: assert property (chg && calm && en_ff[0] &&
    |((general_port_in ^ gp_ff) & ~mask_ff) |-> ##[1:8] int_out)
    else $error("unmasked pin change gave no interrupt");
  a_int_release: assert property (rd && calm && q_ff == 3'h7 &&
    sel_ff == 8'h00 |-> ##2 !int_out)
    else $error("interrupt stayed after status read");
  a_int_hold: assert property (int_out && calm && !psel_in &&
    !$past(psel_in) |=> int_out)
    else $error("interrupt dropped without a read");
  a_wp_deny: assert property (req && calm && wp_on &&
    wp_ff == 4'hF |=> eeprom_cmd_deny_out && !eeprom_cmd_grant_out)
    else $error("blocked command was granted");
  a_wp_allow: assert property (req && calm && wp_ff == 4'h0 |=> ok)
    else $error("command refused with pin low");
  a_wp_ignore: assert property (req && calm && !wp_on |=> ok)
    else $error("command refused with blocking off");
  a_cmd_once: assert property (eeprom_cmd_grant_out ||
    eeprom_cmd_deny_out |-> $past(req) &&
    !(eeprom_cmd_grant_out && eeprom_cmd_deny_out))
    else $error("answer without request");
  a_reset_hiz: assert property (external_reset_pin_in [*4] |->
    general_port_oe_out == 8'h00 && !int_out)
    else $error("pins driven during external reset");
  a_strap_chain: assert property (((addr_pin_used_out + 7'h01) &
    addr_pin_used_out) == 7'h00 && (slave_addr_bits_out &
    ~addr_pin_used_out) == 7'h00)
    else $error("address pins not a chain");
  c_deny: cover property (eeprom_cmd_deny_out);
  c_int: cover property ($rose(int_out));
  c_clear: cover property (rd && int_out);
endmodule
bind epwc_top epwc_top_asserts i_chk (
  .clk_in, .reset_n_in, .external_reset_pin_in, .psel_in, .penable_in,
  .pwrite_in, .paddr_in, .pwdata_in, .general_port_in,
  .general_port_oe_out, .int_out, .int_oe_out, .eeprom_write_block_pin_in,
  .eeprom_cmd_req_in, .eeprom_cmd_grant_out, .eeprom_cmd_deny_out,
  .slave_addr_bits_out, .addr_pin_used_out
);
`default_nettype wire

/* File: verif/epwc_top_tb.sv */
// Self-checking bench for the interrupt, write-block, strap and PWM block
`include "epwc_defines.vh"
`default_nettype none
module epwc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        external_reset_pin_in = 1'b0;
  logic        psel_in = 1'b0;
  logic        penable_in = 1'b0;
  logic        pwrite_in = 1'b0;
  logic [7:0]  paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0;
  logic [7:0]  general_port_in = 8'h00;
  logic        eeprom_write_block_pin_in = 1'b0;
  logic        eeprom_cmd_req_in = 1'b0;
  logic        addr_strap_first_in = 1'b0;
  logic [5:0]  addr_strap_chain_in = 6'h00;
  logic [6:0]  addr_strap_strong_in = 7'h7F;
  logic [4:0]  clk_src_tick_in;
  logic [31:0] prdata_out, rd;
  logic        pready_out, pslverr_out, int_out, int_oe_out, se;
  logic [7:0]  general_port_out, general_port_oe_out;
  logic        eeprom_cmd_grant_out, eeprom_cmd_deny_out;
  logic [6:0]  slave_addr_bits_out, addr_pin_used_out, u;
  int          mismatches = 0, n_checks = 0, i, k, p, w, p3, hi, src, d;
  int          dv [5] = '{8, 1, 2, 4, 16};  // Core cycles per tick
  logic [7:0]  ra [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14, 8'hB4,
                          8'h40, 8'h44, 8'h48};
  logic [31:0] rv [9] = '{32'hFF, 32'h0, 32'hFF, 32'h0, 32'hFF, 32'h04,
                          32'h0, 32'hFF, 32'h0};
  epwc_ticks i_ticks (.clk_in, .tick_out(clk_src_tick_in));
  epwc_top i_dut (
    .clk_in, .reset_n_in, .external_reset_pin_in, .psel_in, .penable_in,
    .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
    .pslverr_out, .clk_src_tick_in, .general_port_in, .general_port_out,
    .general_port_oe_out, .int_out, .int_oe_out,
    .eeprom_write_block_pin_in, .eeprom_cmd_req_in, .eeprom_cmd_grant_out,
    .eeprom_cmd_deny_out, .addr_strap_first_in, .addr_strap_chain_in,
    .addr_strap_strong_in, .slave_addr_bits_out, .addr_pin_used_out
  );
  always #4 clk_in = ~clk_in;
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  task automatic final_report();
    if (mismatches == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // One APB transfer; the request holds until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] dat);
    int t;
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= dat;
    @(posedge clk_in);
    penable_in <= 1'b1;
    t = 0;
    do begin
      @(posedge clk_in);
      t++;
    end while (pready_out !== 1'b1 && t < 16);
    if (pready_out !== 1'b1) begin
      mismatches++;
      final_report();
    end
    rd = prdata_out;
    se = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask
  initial begin
    i = $urandom(32'h8D18E744);
    k = $urandom % 7;
    addr_strap_first_in <= 1'($urandom);
    addr_strap_chain_in <= 6'($urandom);
    addr_strap_strong_in <= 7'h7F << k;  // Pins before k are weak
    u = 7'((2 << k) - 1);
    cyc(4);
    reset_n_in <= 1'b1;
    cyc(3);
    chk("used pins", addr_pin_used_out, u);
    chk("address", slave_addr_bits_out,
        {addr_strap_chain_in, addr_strap_first_in} & u);
    chk("int drive", int_oe_out, 1'b1);
    for (i = 0; i < 9; i++)
      rchk("reset value", ra[i], rv[i]);
    apb(1'b1, 8'h1C, 32'hFF);
    chk("unmapped error", se, 1'b1);
    rchk("unmapped read", 8'h1C, 32'h0);
    // Every blocking combination; pin settles before the request
    for (i = 0; i < 16; i++) begin
      apb(1'b1, `EPWC_A_ENABLE, 32'({i[2:0], 1'b0}));
      eeprom_write_block_pin_in <= i[3];
      cyc(4);
      eeprom_cmd_req_in <= 1'b1;
      cyc(1);
      eeprom_cmd_req_in <= 1'b0;
      cyc(1);
      d = i[0] & i[1] & ~i[2] & i[3];  // Blocked only in this case
      chk("deny", eeprom_cmd_deny_out, d);
      chk("grant", eeprom_cmd_grant_out, !d);
    end
    apb(1'b1, `EPWC_A_ENABLE, 32'h01);
    apb(1'b1, `EPWC_A_MASK, 32'hFE);
    general_port_in <= 8'h02;
    cyc(8);
    chk("masked pin", int_out, 1'b0);
    general_port_in <= 8'h03;
    for (i = 0; i < 10 && int_out !== 1'b1; i++)
      cyc(1);
    chk("interrupt", int_out, 1'b1);
    cyc(4);  // Let the pin pipeline drain before the read
    rchk("status", `EPWC_A_ISTAT, 32'h03);
    cyc(2);
    chk("released", int_out, 1'b0);
    rchk("status cleared", `EPWC_A_ISTAT, 32'h0);
    p = 2 + $urandom % 4;
    w = 1 + $urandom % (p - 1);
    p3 = 2 + $urandom % 3;
    apb(1'b1, 8'h70, 32'h1);
    apb(1'b1, 8'h74, 32'(p3));
    apb(1'b1, 8'h78, 32'h1);
    apb(1'b1, 8'h44, 32'(p));
    apb(1'b1, 8'h48, 32'(w));
    apb(1'b1, `EPWC_A_PWMSEL, 32'h01);
    // Highs in one full period scale with the source's tick spacing
    for (src = 0; src < 6; src++) begin
      d = (src == 5) ? p3 : dv[src];
      apb(1'b1, 8'h40, 32'(src));
      apb(1'b0, `EPWC_A_ISTAT, 32'h0);
      cyc(2 * p * d + 8);
      hi = 0;
      for (i = 0; i < p * d; i++) begin
        cyc(1);
        hi += (general_port_out[0] === 1'b1);
      end
      chk("pwm high", hi, w * d);
      chk("pwm interrupt", int_out, src == 4);
    end
    apb(1'b1, `EPWC_A_OUT, 32'hFE);
    cyc(4);
    chk("output gating", general_port_out[1:0], 2'h2);
    apb(1'b1, `EPWC_A_DIR, 32'h0);
    cyc(3);
    chk("drive on", general_port_oe_out, 8'hFF);
    addr_strap_strong_in <= 7'h01;
    external_reset_pin_in <= 1'b1;
    cyc(6);
    chk("pins released", general_port_oe_out, 8'h00);
    external_reset_pin_in <= 1'b0;
    cyc(6);
    chk("single pin", addr_pin_used_out, 7'h01);
    rchk("enable again", `EPWC_A_ENABLE, 32'h04);
    rchk("mask again", `EPWC_A_MASK, 32'hFF);
    final_report();
  end
endmodule
`default_nettype wire
